/* core/bso_top.sv */
`timescale 1ns/10ps
module bso_top
  import bso_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  opt0_flash,
  input  wire logic [7:0]  opt1_flash,
  input  wire logic        rst_pin,
  input  wire logic        port3_bit6,
  input  wire logic        port3_bit7,
  input  wire logic        port4_bit3,
  input  wire logic        cpu_idle,
  input  wire logic        flash_rd_req,
  input  wire logic        tbl_req,
  input  wire logic        tbl_from_ext,
  input  wire logic        tbl_to_int,
  output logic             cpu_reset_n,
  output logic             boot_loader,
  output logic [7:0]       flash_bank,
  output logic             flash_rd_grant,
  output logic             tbl_grant,
  output logic             clk_range_high,
  output logic             odd_pwm_pin_enable_n,
  output logic             even_pwm_pin_enable_n,
  output logic             odd_pwm_reset_level,
  output logic             even_pwm_reset_level,
  output logic             pwm_ch6_pin_enable_n,
  output logic             pwm_ch7_pin_enable_n,
  output logic             lcd_pin_map_lo,
  output logic             lcd_pin_map_hi
);

  bso_state_e  state_q;
  logic [3:0]  cnt_q;
  logic [7:0]  opt0_q;
  logic [7:0]  opt1_q;
  logic        loaded_q;
  logic [7:0]  isp_q;
  logic [7:0]  bank_q;
  logic        boot_loader_q;
  logic        cpu_reset_n_q;
  logic        waitreq_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        flash_grant_q;
  logic        tbl_grant_q;
  logic        wr_take;
  logic        rd_start;
  logic        wr_lane0;
  logic        sw_reboot;
  logic        idle_loader;
  logic        idle_stay;
  logic        hw_boot;
  logic        lock_open;

  // A bus cycle is taken on the edge at which waitrequest is seen low.
  assign wr_take  = avs_write && !waitreq_q;
  assign rd_start = avs_read && waitreq_q;
  assign wr_lane0 = wr_take && avs_byteenable[0];

  // Software reboot back to the application flash.
  assign sw_reboot = wr_lane0 && (avs_address == BSO_ADDR_ISP) &&
                     (avs_writedata[7:0] == BSO_ISP_SW_REBOOT);

  // Idle entry acts only once the processor is running.
  assign idle_loader = (state_q == BSO_ST_RUN) && cpu_idle &&
                       (isp_q == BSO_ISP_TO_LOADER);
  assign idle_stay   = (state_q == BSO_ST_RUN) && cpu_idle &&
                       (isp_q == BSO_ISP_STAY_APP);

  // Strap-style reboot conditions, each gated by its enable bit.
  assign hw_boot = (!opt0_q[BSO_O0_HW_P3] && !port3_bit6 && !port3_bit7) ||
                   (!opt0_q[BSO_O0_HW_P4] && !port4_bit3);

  // Content stays readable only while the lock bit is still erased high.
  assign lock_open = opt0_q[BSO_O0_LOCK];

  // Sequencer for option-byte load, pin reset, run and reboot pulses.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= BSO_ST_LOAD;
      cnt_q   <= BSO_LOAD_CYC;
    end else begin
      unique case (state_q)
        BSO_ST_LOAD: begin
          if (cnt_q == BSO_CNT_ZERO) begin
            state_q <= BSO_ST_PINRST;
          end else begin
            cnt_q <= cnt_q - BSO_CNT_ONE;
          end
        end
        BSO_ST_PINRST: begin
          if (!rst_pin) begin
            state_q <= BSO_ST_RUN;
          end
        end
        BSO_ST_RUN: begin
          if (rst_pin) begin
            state_q <= BSO_ST_PINRST;
          end else if (idle_loader || sw_reboot) begin
            state_q <= BSO_ST_REBOOT;
            cnt_q   <= BSO_REBOOT_CYC;
          end
        end
        BSO_ST_REBOOT: begin
          if (cnt_q == BSO_CNT_ONE) begin
            state_q <= BSO_ST_RUN;
          end else begin
            cnt_q <= cnt_q - BSO_CNT_ONE;
          end
        end
      endcase
    end
  end

  // Option bytes are latched once, before the processor leaves reset.
  // Nothing on the bus can reach these flops, so their effect is fixed.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      opt0_q   <= BSO_OPT_RST;
      opt1_q   <= BSO_OPT_RST;
      loaded_q <= 1'b0;
    end else if ((state_q == BSO_ST_LOAD) && (cnt_q == BSO_CNT_ZERO)) begin
      opt0_q   <= opt0_flash;
      opt1_q   <= opt1_flash;
      loaded_q <= 1'b1;
    end
  end

  // Execution source; the choice made while the pin is high survives its release.
  // Sampling it again at release would always fall back to the application flash.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_loader_q <= 1'b0;
    end else if ((state_q == BSO_ST_PINRST) && rst_pin) begin
      boot_loader_q <= hw_boot;
    end else if ((state_q == BSO_ST_RUN) && !rst_pin && sw_reboot) begin
      boot_loader_q <= 1'b0;
    end else if (idle_loader && !rst_pin) begin
      boot_loader_q <= 1'b1;
    end
  end

  // Processor reset is held through load, pin reset and reboot pulses.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_reset_n_q <= 1'b0;
    end else begin
      unique case (state_q)
        BSO_ST_LOAD:   cpu_reset_n_q <= 1'b0;
        BSO_ST_PINRST: cpu_reset_n_q <= !rst_pin;
        BSO_ST_RUN:    cpu_reset_n_q <= !(rst_pin || idle_loader || sw_reboot);
        BSO_ST_REBOOT: cpu_reset_n_q <= (cnt_q == BSO_CNT_ONE);
      endcase
    end
  end

  // Boot-control register; it clears itself when a reboot is launched.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      isp_q <= BSO_ISP_RST;
    end else if (sw_reboot || idle_loader) begin
      isp_q <= BSO_ISP_RST;
    end else if (wr_lane0 && (avs_address == BSO_ADDR_ISP)) begin
      isp_q <= avs_writedata[7:0];
    end
  end

  // Bank select steers which flash bank the loader updates.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_q <= BSO_BANK_RST;
    end else if (wr_lane0 && (avs_address == BSO_ADDR_BANK)) begin
      bank_q <= avs_writedata[7:0];
    end
  end

  // Read mux; option bytes read back as zero once the part is locked.
  always_comb begin
    rdata_d = '0;
    unique case (avs_address)
      BSO_ADDR_ISP:  rdata_d[7:0] = isp_q;
      BSO_ADDR_BANK: rdata_d[7:0] = bank_q;
      BSO_ADDR_OPT0: rdata_d[7:0] = lock_open ? opt0_q : 8'h00;
      BSO_ADDR_OPT1: rdata_d[7:0] = lock_open ? opt1_q : 8'h00;
      BSO_ADDR_STATUS: begin
        rdata_d[BSO_ST_LOADER] = boot_loader_q;
        rdata_d[BSO_ST_LOADED] = loaded_q;
      end
      default: rdata_d = '0;
    endcase
  end

  // One wait state per access keeps read data a clean flop output.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitreq_q <= 1'b1;
    end else if ((avs_read || avs_write) && waitreq_q) begin
      waitreq_q <= 1'b0;
    end else begin
      waitreq_q <= 1'b1;
    end
  end

  // Read data is captured on the first request edge and held to the end.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else if (rd_start) begin
      rdata_q <= rdata_d;
    end
  end

  // External content reads pass only while the lock bit is set.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_grant_q <= 1'b0;
    end else begin
      flash_grant_q <= flash_rd_req && lock_open;
    end
  end

  // Table reads from external code may not reach internal memory when inhibited.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tbl_grant_q <= 1'b0;
    end else begin
      tbl_grant_q <= tbl_req && !(!opt0_q[BSO_O0_TBL] && tbl_from_ext && tbl_to_int);
    end
  end

  // Outputs come straight from flops.
  assign avs_readdata          = rdata_q;
  assign avs_waitrequest       = waitreq_q;
  assign cpu_reset_n           = cpu_reset_n_q;
  assign boot_loader           = boot_loader_q;
  assign flash_bank            = bank_q;
  assign flash_rd_grant        = flash_grant_q;
  assign tbl_grant             = tbl_grant_q;
  assign clk_range_high        = opt0_q[BSO_O0_CLK];

  // Pin-function bits feed the port muxes; low means PWM drives push-pull.
  assign odd_pwm_pin_enable_n  = opt1_q[BSO_O1_ODD_EN];
  assign even_pwm_pin_enable_n = opt1_q[BSO_O1_EVEN_EN];
  assign odd_pwm_reset_level   = opt1_q[BSO_O1_ODD_LVL];
  assign even_pwm_reset_level  = opt1_q[BSO_O1_EVN_LVL];
  assign pwm_ch6_pin_enable_n  = opt1_q[BSO_O1_CH6_EN];
  assign pwm_ch7_pin_enable_n  = opt1_q[BSO_O1_CH7_EN];
  assign lcd_pin_map_lo        = opt1_q[BSO_O1_MAP_LO];
  assign lcd_pin_map_hi        = opt1_q[BSO_O1_MAP_HI];

  // Checks run on the core clock and pause under reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_idle_to_loader: assert property (
    (idle_loader && !rst_pin) |=> (boot_loader_q && !cpu_reset_n_q) [*4])
    else $error("idle with 03h did not reboot into loader");

  chk_hw_reboot_sel: assert property (
    (state_q == BSO_ST_PINRST && rst_pin && hw_boot) |=> boot_loader_q)
    else $error("hardware reboot did not select loader");

  chk_bank_write: assert property (
    (wr_lane0 && avs_address == BSO_ADDR_BANK) |=> (bank_q == $past(avs_writedata[7:0])))
    else $error("bank select write lost");

  chk_sw_reboot_app: assert property (
    (sw_reboot && state_q == BSO_ST_RUN && !rst_pin) |=> (!boot_loader_q && !cpu_reset_n_q)
    ##8 cpu_reset_n_q)
    else $error("software reboot sequence wrong");

  chk_idle_stay_app: assert property (
    (idle_stay && !rst_pin && !sw_reboot) |=> (cpu_reset_n_q && $stable(boot_loader_q)))
    else $error("idle with 01h disturbed execution");

  chk_opt_stable: assert property (
    (loaded_q && $past(loaded_q)) |-> ($stable(opt0_q) && $stable(opt1_q)))
    else $error("option bytes changed after load");

  chk_lock_blocks: assert property (
    (flash_rd_req && !lock_open) |=> !flash_grant_q)
    else $error("locked part granted a content read");

  chk_lock_regread: assert property (
    (rd_start && avs_address == BSO_ADDR_OPT0 && !lock_open) |=> (rdata_q == 32'h0000_0000))
    else $error("locked part returned option byte");

  chk_tbl_inhibit: assert property (
    (tbl_req && tbl_from_ext && tbl_to_int && !opt0_q[BSO_O0_TBL]) |=> !tbl_grant_q)
    else $error("inhibited table read granted");

  chk_tbl_free: assert property (
    (tbl_req && opt0_q[BSO_O0_TBL]) |=> tbl_grant_q)
    else $error("unrestricted table read refused");

  chk_load_before_run: assert property (
    cpu_reset_n_q |-> loaded_q)
    else $error("processor released before option load");

  chk_bus_answer: assert property (
    ((avs_read || avs_write) && waitreq_q) |=> !waitreq_q ##1 waitreq_q)
    else $error("bus answer timing wrong");

  // A loader choice made under the pin must still stand when the processor starts.
  chk_hw_boot_hold: assert property (
    (state_q == BSO_ST_PINRST && !rst_pin) |=> $stable(boot_loader_q))
    else $error("loader choice lost at pin release");

  // The processor stays held for as long as the pin is high in the pin-reset state.
  chk_pin_reset_hold: assert property (
    (state_q == BSO_ST_PINRST && rst_pin) |=> !cpu_reset_n_q)
    else $error("processor released under pin reset");

  // The pulse counter keeps the processor held until its last count.
  chk_reboot_pulse: assert property (
    (state_q == BSO_ST_REBOOT && cnt_q != BSO_CNT_ONE) |=> !cpu_reset_n_q)
    else $error("reboot pulse ended early");

  // A launched loader reboot must not fire a second time from a stale code.
  chk_isp_clear: assert property (
    idle_loader |=> (isp_q == BSO_ISP_RST))
    else $error("control register not cleared on reboot");

  // Idle with the stay code leaves the control register alone.
  chk_stay_keeps_isp: assert property (
    (idle_stay && !wr_take) |=> $stable(isp_q))
    else $error("stay code disturbed the control register");

  // Table reads from internal code are never restricted.
  chk_tbl_internal: assert property (
    (tbl_req && !tbl_from_ext) |=> tbl_grant_q)
    else $error("internal table read refused");

  // The second option byte is hidden once the part is locked.
  chk_lock_opt1read: assert property (
    (rd_start && avs_address == BSO_ADDR_OPT1 && !lock_open) |=> (rdata_q == 32'h0000_0000))
    else $error("locked part returned second option byte");

  // An unlocked part still serves content reads.
  chk_lock_open_grant: assert property (
    (flash_rd_req && lock_open) |=> flash_grant_q)
    else $error("unlocked part refused a content read");

  cov_idle_loader: cover property (idle_loader ##[1:20] (cpu_reset_n_q && boot_loader_q));
  cov_sw_reboot:   cover property (sw_reboot ##[1:20] (cpu_reset_n_q && !boot_loader_q));
  cov_hw_reboot:   cover property ((rst_pin && hw_boot) ##1 (!rst_pin && boot_loader_q));
  cov_locked_read: cover property (rd_start && !lock_open);

endmodule

/* core/bso_pkg.sv */
package bso_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [7:0] BSO_ADDR_ISP    = 8'h00;
  localparam logic [7:0] BSO_ADDR_BANK   = 8'h04;
  localparam logic [7:0] BSO_ADDR_OPT0   = 8'h08;
  localparam logic [7:0] BSO_ADDR_OPT1   = 8'h0c;
  localparam logic [7:0] BSO_ADDR_STATUS = 8'h10;

  // Boot-control command codes.
  localparam logic [7:0] BSO_ISP_TO_LOADER = 8'h03;
  localparam logic [7:0] BSO_ISP_STAY_APP  = 8'h01;
  localparam logic [7:0] BSO_ISP_SW_REBOOT = 8'h83;

  // Reset values.
  localparam logic [7:0] BSO_ISP_RST  = 8'h00;
  localparam logic [7:0] BSO_BANK_RST = 8'h00;
  localparam logic [7:0] BSO_OPT_RST  = 8'hff;

  // Option byte zero field positions.
  localparam int BSO_O0_LOCK  = 0;
  localparam int BSO_O0_TBL   = 1;
  localparam int BSO_O0_HW_P3 = 4;
  localparam int BSO_O0_HW_P4 = 5;
  localparam int BSO_O0_CLK   = 7;

  // Option byte one field positions.
  localparam int BSO_O1_ODD_EN  = 0;
  localparam int BSO_O1_EVEN_EN = 1;
  localparam int BSO_O1_ODD_LVL = 2;
  localparam int BSO_O1_EVN_LVL = 3;
  localparam int BSO_O1_MAP_LO  = 4;
  localparam int BSO_O1_MAP_HI  = 5;
  localparam int BSO_O1_CH6_EN  = 6;
  localparam int BSO_O1_CH7_EN  = 7;

  // Status register field positions.
  localparam int BSO_ST_LOADER = 0;
  localparam int BSO_ST_LOADED = 1;

  // Timing counts in clock cycles.
  localparam logic [3:0] BSO_LOAD_CYC   = 4'h4;
  localparam logic [3:0] BSO_REBOOT_CYC = 4'h8;
  localparam logic [3:0] BSO_CNT_ONE    = 4'h1;
  localparam logic [3:0] BSO_CNT_ZERO   = 4'h0;

  typedef enum logic [1:0] {
    BSO_ST_LOAD,
    BSO_ST_PINRST,
    BSO_ST_RUN,
    BSO_ST_REBOOT
  } bso_state_e;

endpackage

/* verification/bso_partner.sv */
`timescale 1ns/10ps
// Programmer side: presents the programmed option bytes while the power-up load runs, then lets them wander.
module bso_partner (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] prog0,
  input  wire logic [7:0] prog1,
  output logic [7:0]      opt0_flash,
  output logic [7:0]      opt1_flash
);
  logic [3:0] age_q;
  logic       wob_q;

  // Age since power-up release; later flash reads must not reach the latched options.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      age_q <= 4'h0;
      wob_q <= 1'b0;
    end else begin
      wob_q <= !wob_q;
      if (age_q != 4'h8) age_q <= age_q + 4'h1;
    end
  end

  // The core clock runs above the range boundary, so the range bit is always programmed high.
  assign opt0_flash = (age_q == 4'h8) ? (prog0 ^ 8'h5a ^ {8{wob_q}}) : {1'b1, prog0[6:0]};
  assign opt1_flash = (age_q == 4'h8) ? (prog1 ^ 8'ha5 ^ {8{wob_q}}) : prog1;
endmodule

/* verification/bso_top_tb.sv */
`timescale 1ns/10ps
`define CHK(g, e) check(32'(g), 32'(e))
module bso_top_tb
  import bso_pkg::*;
;
  logic        clk, arst_n, avs_read, avs_write, avs_waitrequest, rst_pin, cpu_idle;
  logic        port3_bit6, port3_bit7, port4_bit3, flash_rd_req, tbl_req, tbl_from_ext, tbl_to_int;
  logic        cpu_reset_n, boot_loader, flash_rd_grant, tbl_grant, clk_range_high;
  logic        odd_pwm_pin_enable_n, even_pwm_pin_enable_n, odd_pwm_reset_level, even_pwm_reset_level;
  logic        pwm_ch6_pin_enable_n, pwm_ch7_pin_enable_n, lcd_pin_map_lo, lcd_pin_map_hi;
  logic [3:0]  avs_byteenable;
  logic [7:0]  avs_address, flash_bank, opt0_flash, opt1_flash, prog0, prog1;
  logic [31:0] avs_writedata, avs_readdata;
  logic [31:0] exp_q[$];
  int          n_mismatch, tests_run;
  wire [7:0]   opt_vec = {pwm_ch7_pin_enable_n, pwm_ch6_pin_enable_n, lcd_pin_map_hi, lcd_pin_map_lo,
                          even_pwm_reset_level, odd_pwm_reset_level, even_pwm_pin_enable_n, odd_pwm_pin_enable_n};

  bso_top dut (
    .clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .opt0_flash(opt0_flash), .opt1_flash(opt1_flash), .rst_pin(rst_pin),
    .port3_bit6(port3_bit6), .port3_bit7(port3_bit7), .port4_bit3(port4_bit3), .cpu_idle(cpu_idle),
    .flash_rd_req(flash_rd_req), .tbl_req(tbl_req), .tbl_from_ext(tbl_from_ext), .tbl_to_int(tbl_to_int),
    .cpu_reset_n(cpu_reset_n), .boot_loader(boot_loader), .flash_bank(flash_bank),
    .flash_rd_grant(flash_rd_grant), .tbl_grant(tbl_grant), .clk_range_high(clk_range_high),
    .odd_pwm_pin_enable_n(odd_pwm_pin_enable_n), .even_pwm_pin_enable_n(even_pwm_pin_enable_n),
    .odd_pwm_reset_level(odd_pwm_reset_level), .even_pwm_reset_level(even_pwm_reset_level),
    .pwm_ch6_pin_enable_n(pwm_ch6_pin_enable_n), .pwm_ch7_pin_enable_n(pwm_ch7_pin_enable_n),
    .lcd_pin_map_lo(lcd_pin_map_lo), .lcd_pin_map_hi(lcd_pin_map_hi));

  bso_partner far_end (.clk(clk), .arst_n(arst_n), .prog0(prog0), .prog1(prog1),
                       .opt0_flash(opt0_flash), .opt1_flash(opt1_flash));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Holds the request until the edge that samples waitrequest low, then releases it.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= d;
    avs_byteenable <= be;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic idle_pulse();
    @(posedge clk);
    cpu_idle <= 1'b1;
    @(posedge clk);
    cpu_idle <= 1'b0;
  endtask

  // Measures how many edges the processor stays in reset once the reset is seen.
  task automatic reset_len(output int n);
    int k;
    k = 0;
    n = 0;
    #1;
    while (cpu_reset_n !== 1'b0 && k < 20) begin
      @(posedge clk);
      #1;
      k++;
    end
    while (cpu_reset_n === 1'b0 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask

  task automatic power_up(input logic [1:0] m);
    logic [31:0] r;
    logic [7:0]  o0;
    logic [7:0]  o1;
    logic        hb;
    int          k;
    r  = $urandom;
    o0 = {1'b1, r[6], m[1], m[0], r[3:2], m[1], m != 2'h0};
    o1 = {r[15:14], m, r[11:8]};
    @(posedge clk);
    arst_n <= 1'b0;
    prog0  <= {r[7], o0[6:0]};
    prog1  <= o1;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    k = 0;
    while (cpu_reset_n !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    #1;
    `CHK(cpu_reset_n, 1'b1);
    `CHK(opt_vec, o1);
    `CHK(clk_range_high, 1'b1);
    rd(BSO_ADDR_OPT0, o0[0] ? o0 : 8'h00);
    bus(1'b1, BSO_ADDR_OPT1, 32'h0, 4'hf);
    rd(BSO_ADDR_OPT1, o0[0] ? o1 : 8'h00);
    rd(8'h14, 32'h0);
    rd(BSO_ADDR_STATUS, 32'h2);
    // Every request and table-read source combination, granted one cycle later.
    for (k = 0; k < 16; k++) begin
      @(posedge clk);
      {flash_rd_req, tbl_req, tbl_from_ext, tbl_to_int} <= 4'(k);
      @(posedge clk);
      #1;
      `CHK(flash_rd_grant, k[3] & o0[0]);
      `CHK(tbl_grant, k[2] & !(!o0[1] & k[1] & k[0]));
    end
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      {port3_bit6, port3_bit7, port4_bit3} <= 3'(k);
      rst_pin <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK(cpu_reset_n, 1'b0);
      hb = (!o0[4] & !k[2] & !k[1]) | (!o0[5] & !k[0]);
      `CHK(boot_loader, hb);
      @(posedge clk);
      rst_pin <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHK(cpu_reset_n, 1'b1);
      `CHK(boot_loader, hb);
    end
    bus(1'b1, BSO_ADDR_ISP, BSO_ISP_STAY_APP, 4'he);
    rd(BSO_ADDR_ISP, 32'h0);
    bus(1'b1, BSO_ADDR_ISP, BSO_ISP_STAY_APP, 4'hf);
    idle_pulse();
    repeat (10) @(posedge clk);
    #1;
    `CHK({cpu_reset_n, boot_loader}, 2'b10);
    rd(BSO_ADDR_ISP, BSO_ISP_STAY_APP);
    bus(1'b1, BSO_ADDR_ISP, BSO_ISP_TO_LOADER, 4'hf);
    bus(1'b1, BSO_ADDR_BANK, r[23:16], 4'hf);
    rd(BSO_ADDR_BANK, r[23:16]);
    `CHK(flash_bank, r[23:16]);
    idle_pulse();
    reset_len(k);
    `CHK(k, BSO_REBOOT_CYC);
    `CHK(boot_loader, 1'b1);
    rd(BSO_ADDR_STATUS, 32'h3);
    bus(1'b1, BSO_ADDR_ISP, BSO_ISP_SW_REBOOT, 4'hf);
    reset_len(k);
    `CHK(k, BSO_REBOOT_CYC);
    `CHK(boot_loader, 1'b0);
  endtask

  // Free-running core clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Read data is due at the edge where waitrequest is sampled low with the read still up.
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0);
      else `CHK(avs_readdata, exp_q.pop_front());
    end
  end

  // Cuts a hang short; the whole sequence needs well under a tenth of this span.
  initial begin
    #300000;
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence: four power-ups cover every pin allocation code and both lock states.
  initial begin
    {avs_read, avs_write, rst_pin, cpu_idle} = 4'h0;
    {flash_rd_req, tbl_req, tbl_from_ext, tbl_to_int} = 4'h0;
    {port3_bit6, port3_bit7, port4_bit3} = 3'h7;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    prog0 = 8'hff;
    prog1 = 8'hff;
    arst_n = 1'b0;
    n_mismatch = 0;
    tests_run = 0;
    void'($urandom(32'hc784));
    for (int i = 0; i < 4; i++) power_up(2'(i));
    tally_and_finish();
  end
endmodule
